// >>> hdl/fault_retry_pkg.sv
`default_nettype none
package fault_retry_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // Register offsets
  localparam logic [7:0] OFF_RESPONSE = 8'h00;
  localparam logic [7:0] OFF_CONTROL = 8'h01;
  localparam logic [7:0] OFF_STATUS = 8'h02;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h03;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h04;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h05;
  localparam logic [7:0] OFF_TIME_UNIT = 8'hd2;

  // Fault-response byte fields
  localparam int RESP_LSB = 6;
  localparam int RETRY_LSB = 3;
  localparam int DELAY_LSB = 0;

  // Reset values
  localparam logic [7:0] RESPONSE_RST = 8'h80;
  localparam logic [15:0] TIME_UNIT_RST = 16'h0028;
  localparam logic [4:0] IRQ_ENABLE_RST = 5'h00;

  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // Control register bit
  localparam int CTRL_CLEAR_BIT = 0;

  // Status register layout
  localparam int ST_STATE_LSB = 0;
  localparam int ST_COUNT_LSB = 8;
  localparam int ST_LATCH_BIT = 11;
  localparam int ST_OUT_BIT = 12;
  localparam int ST_FAULT_BIT = 13;

  // Interrupt events
  localparam int EV_FAULT = 0;
  localparam int EV_SHUTDOWN = 1;
  localparam int EV_RETRY = 2;
  localparam int EV_LATCH = 3;
  localparam int EV_RECOVER = 4;
  localparam int EV_W = 5;

  typedef enum logic [1:0] {
    RESP_IGNORE = 2'h0,
    RESP_DEFER = 2'h1,
    RESP_DISABLE_RETRY = 2'h2,
    RESP_HOLD_OFF = 2'h3
  } resp_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // Delay code doubles per step: 0->1, 1->2, 2->4 ... 7->128 units
  function automatic logic [7:0] delay_units(input logic [2:0] code);
    delay_units = 8'h01 << code;
  endfunction
endpackage
`default_nettype wire

// >>> hdl/delay_timer.sv
`default_nettype none
module delay_timer #(
  parameter int UNIT_W = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Control
  input wire logic start,
  input wire logic stop,
  input wire logic [2:0] code,
  input wire logic [UNIT_W-1:0] unitCycles,
  // Result
  output logic running,
  output logic done
);
  import fault_retry_pkg::*;

  logic [UNIT_W-1:0] unitCnt;
  logic [7:0] unitsLeft;
  wire logic [UNIT_W-1:0] unitLoad;
  wire logic unitWrap;
  wire logic lastUnit;

  // A zero unit would never expire, so it counts as one cycle
  assign unitLoad = (unitCycles == '0) ? '0 : unitCycles - UNIT_W'(1);
  assign unitWrap = running && (unitCnt == '0);
  assign lastUnit = unitWrap && (unitsLeft == 8'h01);
  // Done comes straight from the count so the next interval starts on the expiring edge
  assign done = lastUnit;

  always_ff @(posedge core_clk) begin
    if (!reset_n || stop) begin
      running <= 1'b0;
      unitCnt <= '0;
      unitsLeft <= 8'h00;
    end else if (start) begin
      running <= 1'b1;
      unitCnt <= unitLoad;
      unitsLeft <= delay_units(code);
    end else begin
      if (lastUnit) begin
        running <= 1'b0;
      end
      if (unitWrap) begin
        unitCnt <= unitLoad;
        unitsLeft <= unitsLeft - 8'h01;
      end else if (running) begin
        unitCnt <= unitCnt - UNIT_W'(1);
      end
    end
  end
endmodule
`default_nettype wire

// >>> hdl/fault_retry_sequencer.sv
// Operation
// - Retry codes 1-6 give that many restarts
// - Retries exhausted: output off until cleared
// - Attempt spacing equals delay count times unit
// - Retry code 7 retries until stopped
// - Delay code doubles units per step
// - Delay count serves deferral and spacing
// - Time unit comes from register 0xD2
// - Response 00 ignores the fault
// - Response 01 runs through delay first
// - 10 shuts then retries; 11 holds off
// - Retry code 0: stay off until cleared
`default_nettype none
module fault_retry_sequencer #(
  parameter int UNIT_W = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Register port
  input wire fault_retry_pkg::reg_req_t regReq,
  output logic [fault_retry_pkg::DATA_W-1:0] rdData,
  // Power stage
  input wire logic faultIn,
  input wire logic otherFault,
  input wire logic outputOnCmd,
  output logic outputEnable,
  output logic latchedFault,
  // Interrupt
  output logic irq
);
  import fault_retry_pkg::*;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_RUN = 7'h02,
    ST_DEFER = 7'h04,
    ST_OFF_WAIT = 7'h08,
    ST_ATTEMPT = 7'h10,
    ST_LATCHED = 7'h20,
    ST_HOLD_OFF = 7'h40
  } state_t;

  state_t state;
  state_t next_state;

  // Where a shutdown leads: straight to latched when no retry is allowed
  function automatic state_t afterShutdown(input logic [2:0] retries);
    afterShutdown = (retries == RETRY_NONE) ? ST_LATCHED : ST_OFF_WAIT;
  endfunction

  // States in which the delay timer must keep counting
  function automatic logic timedState(input state_t s);
    timedState = (s == ST_DEFER) || (s == ST_OFF_WAIT) || (s == ST_ATTEMPT);
  endfunction

  // Address match qualified by one strobe
  function automatic logic regHit(input logic strobe, input logic [ADDR_W-1:0] addr,
                                  input logic [7:0] off);
    regHit = strobe && (addr == off);
  endfunction

  logic [7:0] response;
  logic [UNIT_W-1:0] timeUnit;
  logic [EV_W-1:0] irqStatus;
  logic [EV_W-1:0] irqEnable;
  logic [2:0] attemptsDone;
  logic attemptFailed;

  // Register decode
  wire logic wrResponse;
  wire logic wrControl;
  wire logic wrIrqClear;
  wire logic wrIrqEnable;
  wire logic wrTimeUnit;
  assign wrResponse = regHit(regReq.wr, regReq.addr, OFF_RESPONSE);
  assign wrControl = regHit(regReq.wr, regReq.addr, OFF_CONTROL);
  assign wrIrqClear = regHit(regReq.wr, regReq.addr, OFF_IRQ_CLEAR);
  assign wrIrqEnable = regHit(regReq.wr, regReq.addr, OFF_IRQ_ENABLE);
  assign wrTimeUnit = regHit(regReq.wr, regReq.addr, OFF_TIME_UNIT);

  // Fault-response fields
  wire resp_t respMode;
  wire logic [2:0] retryCode;
  wire logic [2:0] delayCode;
  assign respMode = resp_t'(response[RESP_LSB +: 2]);
  assign retryCode = response[RETRY_LSB +: 3];
  assign delayCode = response[DELAY_LSB +: 3];

  // Retry bookkeeping
  wire logic retryForever;
  wire logic retriesLeft;
  wire logic faultHit;
  assign retryForever = (retryCode == RETRY_FOREVER);
  assign retriesLeft = retryForever || (attemptsDone < retryCode);
  assign faultHit = faultIn || otherFault;

  // Timer control
  wire logic timerDone;
  wire logic timerStart;
  wire logic timerStop;

  // Commanded off, or a clear while latched, abandons the sequence
  wire logic cmdOff;
  wire logic clearLatch;
  assign cmdOff = !outputOnCmd;
  assign clearLatch = wrControl && regReq.wdata[CTRL_CLEAR_BIT];

  // State transitions
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        // A standing forced-shutdown fault keeps the output from starting
        if (outputOnCmd && !latchedFault && !otherFault) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (cmdOff) begin
          next_state = ST_IDLE;
        end else if (otherFault) begin
          next_state = ST_LATCHED;
        end else if (faultIn) begin
          case (respMode)
            RESP_IGNORE: next_state = ST_RUN;
            RESP_DEFER: next_state = ST_DEFER;
            RESP_DISABLE_RETRY: begin
              next_state = afterShutdown(retryCode);
            end
            RESP_HOLD_OFF: next_state = ST_HOLD_OFF;
            default: next_state = ST_RUN;
          endcase
        end
      end
      ST_DEFER: begin
        if (cmdOff) begin
          next_state = ST_IDLE;
        end else if (otherFault) begin
          next_state = ST_LATCHED;
        end else if (!faultIn) begin
          next_state = ST_RUN;
        end else if (timerDone) begin
          next_state = afterShutdown(retryCode);
        end
      end
      ST_OFF_WAIT: begin
        if (cmdOff) begin
          next_state = ST_IDLE;
        end else if (otherFault) begin
          next_state = ST_LATCHED;
        end else if (timerDone) begin
          next_state = retriesLeft ? ST_ATTEMPT : ST_LATCHED;
        end
      end
      ST_ATTEMPT: begin
        if (cmdOff) begin
          next_state = ST_IDLE;
        end else if (otherFault) begin
          next_state = ST_LATCHED;
        end else if (timerDone) begin
          if (!attemptFailed && !faultIn) begin
            next_state = ST_RUN;
          end else if (retriesLeft) begin
            next_state = ST_ATTEMPT;
          end else begin
            next_state = ST_LATCHED;
          end
        end
      end
      ST_LATCHED: begin
        if (clearLatch || cmdOff) begin
          next_state = ST_IDLE;
        end
      end
      ST_HOLD_OFF: begin
        if (cmdOff) begin
          next_state = ST_IDLE;
        end else if (otherFault) begin
          next_state = ST_LATCHED;
        end else if (!faultIn) begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // Timer is restarted on every entry that begins a timed interval
  wire logic enterDefer;
  wire logic enterOffWait;
  wire logic newAttempt;
  assign enterDefer = (next_state == ST_DEFER) && (state != ST_DEFER);
  assign enterOffWait = (next_state == ST_OFF_WAIT) && (state != ST_OFF_WAIT);
  assign newAttempt = (next_state == ST_ATTEMPT) && (state != ST_ATTEMPT || timerDone);
  assign timerStart = enterDefer || enterOffWait || newAttempt;
  assign timerStop = !timedState(next_state);

  delay_timer #(
    .UNIT_W(UNIT_W)
  ) u_timer (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .start(timerStart),
    .stop(timerStop),
    .code(delayCode),
    .unitCycles(timeUnit),
    .running(),
    .done(timerDone)
  );

  // An attempt that sees the fault stays failed until its interval ends
  wire logic failNext;
  assign failNext = (next_state == ST_ATTEMPT) && !newAttempt && attemptFailed;

  // Output drive follows the next state so it leaves with the state change
  wire logic next_outputEnable;
  assign next_outputEnable = (next_state == ST_RUN) || (next_state == ST_DEFER)
                             || (next_state == ST_ATTEMPT && !faultHit && !failNext);

  // Events
  wire logic [EV_W-1:0] events;
  assign events[EV_FAULT] = (state == ST_RUN) && faultHit && outputOnCmd;
  assign events[EV_SHUTDOWN] = outputEnable && !next_outputEnable && outputOnCmd;
  assign events[EV_RETRY] = newAttempt;
  assign events[EV_LATCH] = (next_state == ST_LATCHED) && (state != ST_LATCHED);
  assign events[EV_RECOVER] = (next_state == ST_RUN)
                              && (state != ST_RUN) && (state != ST_IDLE);

  wire logic [EV_W-1:0] irqClearMask;
  assign irqClearMask = wrIrqClear ? regReq.wdata[EV_W-1:0] : '0;

  // Read decode
  wire logic rdResponse;
  wire logic rdStatus;
  wire logic rdIrqStatus;
  wire logic rdIrqEnable;
  wire logic rdTimeUnit;
  assign rdResponse = regHit(regReq.rd, regReq.addr, OFF_RESPONSE);
  assign rdStatus = regHit(regReq.rd, regReq.addr, OFF_STATUS);
  assign rdIrqStatus = regHit(regReq.rd, regReq.addr, OFF_IRQ_STATUS);
  assign rdIrqEnable = regHit(regReq.rd, regReq.addr, OFF_IRQ_ENABLE);
  assign rdTimeUnit = regHit(regReq.rd, regReq.addr, OFF_TIME_UNIT);

  // Read mux
  wire logic [DATA_W-1:0] statusWord;
  wire logic [DATA_W-1:0] next_rdData;
  assign statusWord = (DATA_W'(state) << ST_STATE_LSB)
                      | (DATA_W'(attemptsDone) << ST_COUNT_LSB)
                      | (DATA_W'(latchedFault) << ST_LATCH_BIT)
                      | (DATA_W'(outputEnable) << ST_OUT_BIT)
                      | (DATA_W'(faultIn) << ST_FAULT_BIT);
  assign next_rdData = rdResponse ? DATA_W'(response) :
                       rdStatus ? statusWord :
                       rdIrqStatus ? DATA_W'(irqStatus) :
                       rdIrqEnable ? DATA_W'(irqEnable) :
                       rdTimeUnit ? DATA_W'(timeUnit) :
                       '0;

  // Software registers
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      response <= RESPONSE_RST;
      timeUnit <= TIME_UNIT_RST;
      irqEnable <= IRQ_ENABLE_RST;
    end else begin
      if (wrResponse) begin
        response <= regReq.wdata[7:0];
      end
      if (wrTimeUnit) begin
        timeUnit <= regReq.wdata[UNIT_W-1:0];
      end
      if (wrIrqEnable) begin
        irqEnable <= regReq.wdata[EV_W-1:0];
      end
    end
  end

  // Sequencer state
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      latchedFault <= 1'b0;
      attemptFailed <= 1'b0;
    end else begin
      state <= next_state;
      latchedFault <= (next_state == ST_LATCHED);
      attemptFailed <= (next_state == ST_ATTEMPT) && (failNext || faultHit);
    end
  end

  // Output stage drive
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      outputEnable <= 1'b0;
    end else begin
      outputEnable <= next_outputEnable;
    end
  end

  // Attempt counter runs from the shutdown until normal operation returns
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      attemptsDone <= 3'h0;
    end else if (next_state == ST_RUN || next_state == ST_IDLE) begin
      attemptsDone <= 3'h0;
    // Endless retry is not counted, so the three-bit count cannot wrap
    end else if (newAttempt && !retryForever) begin
      attemptsDone <= attemptsDone + 3'h1;
    end
  end

  // Interrupts: a new event wins over a clear in the same cycle
  wire logic [EV_W-1:0] next_irqStatus;
  for (genvar i = 0; i < EV_W; i++) begin : g_irqBit
    assign next_irqStatus[i] = events[i] || (irqStatus[i] && !irqClearMask[i]);
  end

  // The level output follows the next status so it has no extra lag
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      irqStatus <= '0;
      irq <= 1'b0;
    end else begin
      irqStatus <= next_irqStatus;
      irq <= |(next_irqStatus & irqEnable);
    end
  end

  // Read data stand for one cycle only; an idle port reads zero
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rdData <= '0;
    end else begin
      rdData <= next_rdData;
    end
  end
endmodule
`default_nettype wire

// >>> verif/fault_retry_props.sv
`default_nettype none
module fault_retry_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Watched ports
  input wire fault_retry_pkg::reg_req_t regReq,
  input wire logic [fault_retry_pkg::DATA_W-1:0] rdData,
  input wire logic otherFault,
  input wire logic outputOnCmd,
  input wire logic outputEnable,
  input wire logic latchedFault
);
  timeunit 1ns;
  timeprecision 1ps;
  import fault_retry_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wire clrReq = regReq.wr && regReq.addr == OFF_CONTROL && regReq.wdata[CTRL_CLEAR_BIT];
  sequence cmdOff;
    !outputOnCmd;
  endsequence
  sequence inLatch;
    latchedFault && outputOnCmd && !clrReq;
  endsequence
  rd_idle_a: assert property (!$past(regReq.rd) |-> rdData == '0)
    else $error("read data outside read slot");
  latch_off_a: assert property (latchedFault |-> !outputEnable)
    else $error("output on while latched");
  latch_hold_a: assert property (inLatch |=> latchedFault)
    else $error("latch left without clear");
  latch_fall_a: assert property ($fell(latchedFault) |-> $past(clrReq) || !$past(outputOnCmd))
    else $error("latch fell without cause");
  cmd_off_a: assert property (cmdOff |=> !outputEnable && !latchedFault)
    else $error("command off ignored");
  other_off_a: assert property (otherFault |=> !outputEnable)
    else $error("other fault did not shut down");
  rise_cmd_a: assert property ($rose(outputEnable) |-> $past(outputOnCmd) && !$past(otherFault))
    else $error("output rose without command");
  latch_rise_a: assert property ($rose(latchedFault) |-> $past(outputOnCmd))
    else $error("latched while commanded off");
endmodule
`default_nettype wire

// >>> verif/pmbus_host_model.sv
`default_nettype none
module pmbus_host_model (
  // Clock
  input wire logic core_clk,
  // Register port
  output var fault_retry_pkg::reg_req_t regReq,
  input wire logic [fault_retry_pkg::DATA_W-1:0] rdData
);
  timeunit 1ns;
  timeprecision 1ps;
  import fault_retry_pkg::*;
  initial regReq = '0;
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge core_clk);
    regReq <= '{a, v, 1'b1, 1'b0};
    @(posedge core_clk);
    regReq.wr <= 1'b0;
    #1;
  endtask
  // Read data exist only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge core_clk);
    regReq <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge core_clk);
    regReq.rd <= 1'b0;
    #1 v = rdData;
  endtask
endmodule
`default_nettype wire

// >>> verif/tb_fault_retry_sequencer.sv
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
`define WAIT(cond, lim) k = 0; while (!(cond) && k < (lim)) begin @(posedge core_clk); #1 k++; end \
  if (!(cond)) begin n_errors++; $display("[FAIL] wait expected 1 seen 0"); end
module tb_fault_retry_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import fault_retry_pkg::*;
  localparam logic [15:0] U = 16'h0004;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  reg_req_t regReq;
  logic [DATA_W-1:0] rdData, d;
  logic faultIn = 1'b0;
  logic otherFault = 1'b0;
  logic outputOnCmd = 1'b0;
  logic outputEnable, latchedFault, irq;
  int n_errors = 0;
  int compares = 0;
  int k, t;
  integer seed = 32'h7326;
  always #12.5 core_clk = ~core_clk;
  fault_retry_sequencer uut (.core_clk(core_clk), .reset_n(reset_n), .regReq(regReq),
    .rdData(rdData), .faultIn(faultIn), .otherFault(otherFault), .outputOnCmd(outputOnCmd),
    .outputEnable(outputEnable), .latchedFault(latchedFault), .irq(irq));
  pmbus_host_model host (.core_clk(core_clk), .regReq(regReq), .rdData(rdData));
  function automatic int interval(input logic [2:0] c);
    return (1 << c) * int'(U);
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic complete_run();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic latchRun(input logic [2:0] c, input logic [2:0] r);
    host.wr(OFF_IRQ_CLEAR, 16'h001f);
    host.wr(OFF_RESPONSE, {8'h00, RESP_DISABLE_RETRY, r, c});
    @(posedge core_clk) faultIn <= 1'b1;
    if (r > 1) begin
      // Both edges see the same irq latency, so their distance is the spacing
      `WAIT(irq === 1'b1, 2000)
      host.wr(OFF_IRQ_CLEAR, 16'h001f);
      `WAIT(irq === 1'b0, 4)
      t = k;
      `WAIT(irq === 1'b1, 2000)
      `CHK("spacing", interval(c), t + k + 2)
    end
    `WAIT(latchedFault === 1'b1, 9000)
    host.rd(OFF_STATUS, d);
    `CHK("status", {3'b101, r}, d[13:8])
    @(posedge core_clk) faultIn <= 1'b0;
    cyc(20);
    `CHK("held", 1'b1, latchedFault)
    host.wr(OFF_CONTROL, 16'h0001);
    `WAIT(outputEnable === 1'b1, 10)
    `CHK("cleared", 2'b10, {outputEnable, latchedFault})
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    host.rd(OFF_RESPONSE, d);
    `CHK("response reset", {8'h00, RESPONSE_RST}, d)
    host.rd(OFF_TIME_UNIT, d);
    `CHK("unit reset", TIME_UNIT_RST, d)
    host.rd(OFF_IRQ_ENABLE, d);
    `CHK("enable reset", {11'h000, IRQ_ENABLE_RST}, d)
    host.wr(8'h07, 16'($random(seed)));
    host.rd(8'h07, d);
    `CHK("unmapped", 16'h0000, d)
    host.wr(OFF_TIME_UNIT, U);
    host.rd(OFF_TIME_UNIT, d);
    `CHK("unit", U, d)
    host.wr(OFF_IRQ_ENABLE, 16'h0001 << EV_RETRY);
    @(posedge core_clk) outputOnCmd <= 1'b1;
    `WAIT(outputEnable === 1'b1, 10)
    for (int c = 0; c < 8; c++) begin
      latchRun(3'(c), 3'(2 + {$random(seed)} % 5));
    end
    latchRun(3'h0, 3'h1);
    host.wr(OFF_IRQ_ENABLE, 16'h0000);
    latchRun(3'h0, RETRY_NONE);
    `CHK("masked irq", 1'b0, irq)
    host.rd(OFF_IRQ_STATUS, d);
    `CHK("latch event", 1'b1, d[EV_LATCH])
    host.wr(OFF_IRQ_ENABLE, 16'h0001 << EV_LATCH);
    `WAIT(irq === 1'b1, 4)
    host.wr(OFF_IRQ_CLEAR, 16'h001f);
    `WAIT(irq === 1'b0, 4)
    `CHK("irq clear", 1'b0, irq)
    host.wr(OFF_RESPONSE, {8'h00, RESP_DISABLE_RETRY, RETRY_FOREVER, 3'h0});
    @(posedge core_clk) faultIn <= 1'b1;
    cyc(40 * int'(U));
    `CHK("endless retry", 1'b0, latchedFault)
    @(posedge core_clk) otherFault <= 1'b1;
    `WAIT(latchedFault === 1'b1, 4)
    `CHK("other fault", 2'b10, {latchedFault, outputEnable})
    @(posedge core_clk) begin
      otherFault <= 1'b0;
      faultIn <= 1'b0;
      outputOnCmd <= 1'b0;
    end
    `WAIT(latchedFault === 1'b0, 4)
    @(posedge core_clk) outputOnCmd <= 1'b1;
    `WAIT(outputEnable === 1'b1, 4)
    `CHK("command cycle", 1'b1, outputEnable)
    host.wr(OFF_RESPONSE, {8'h00, RESP_DEFER, 3'h1, 3'h2});
    @(posedge core_clk) faultIn <= 1'b1;
    cyc(8);
    @(posedge core_clk) faultIn <= 1'b0;
    cyc(40);
    `CHK("defer recover", 2'b10, {outputEnable, latchedFault})
    @(posedge core_clk) faultIn <= 1'b1;
    cyc(interval(3'h2) - 4);
    `CHK("defer on", 1'b1, outputEnable)
    cyc(8);
    `CHK("defer off", 1'b0, outputEnable)
    `WAIT(latchedFault === 1'b1, 200)
    @(posedge core_clk) faultIn <= 1'b0;
    host.wr(OFF_CONTROL, 16'h0001);
    host.wr(OFF_RESPONSE, {8'h00, RESP_HOLD_OFF, 3'h0, 3'h0});
    @(posedge core_clk) faultIn <= 1'b1;
    cyc(30);
    `CHK("hold off", 2'b00, {outputEnable, latchedFault})
    @(posedge core_clk) faultIn <= 1'b0;
    `WAIT(outputEnable === 1'b1, 4)
    `CHK("resume", 1'b1, outputEnable)
    host.wr(OFF_RESPONSE, {8'h00, RESP_IGNORE, 3'h0, 3'h0});
    @(posedge core_clk) faultIn <= 1'b1;
    cyc(50);
    `CHK("ignore", 2'b10, {outputEnable, latchedFault})
    // A second reset in mid-run must restore idle outputs and the response register default
    @(posedge core_clk) begin
      faultIn <= 1'b0;
      reset_n <= 1'b0;
    end
    cyc(2);
    `CHK("reset outputs", 3'b000, {outputEnable, latchedFault, irq})
    @(posedge core_clk) reset_n <= 1'b1;
    host.rd(OFF_RESPONSE, d);
    `CHK("response after reset", {8'h00, RESPONSE_RST}, d)
    complete_run();
  end
  // Longest path is about ten thousand cycles; this leaves ample margin
  initial begin
    #(25 * 60000);
    n_errors++;
    complete_run();
  end
endmodule
bind fault_retry_sequencer fault_retry_props props (.core_clk(core_clk), .reset_n(reset_n),
  .regReq(regReq), .rdData(rdData), .otherFault(otherFault), .outputOnCmd(outputOnCmd),
  .outputEnable(outputEnable), .latchedFault(latchedFault));
`default_nettype wire
